// >>> include/psc_pkg.sv
// constants and types shared by the pipelined sram pin-control block
`default_nettype none
package psc_pkg;
  localparam int ADDR_W     = 18;
  localparam int DATA_W     = 32;
  localparam int LANES      = 4;
  localparam int LANE_W     = 8;
  localparam int MEM_IDX_W  = 6;
  localparam int FIFO_DEPTH = 16;
  localparam int WORD_W     = MEM_IDX_W + DATA_W + LANES + LANES;
  localparam int BURST_W    = 2;
  // strap is taken this many cycles after reset release, once its synchroniser has filled
  localparam logic [1:0] STRAP_WAIT    = 2'h3;
  localparam logic       MODE_RESET    = 1'h1;
  localparam logic       IR_CAPTURE    = 1'h1;
  localparam logic       DR_CAPTURE    = 1'h0;

  typedef enum logic [2:0] {
    PSC_OP_IDLE  = 3'h1,
    PSC_OP_READ  = 3'h2,
    PSC_OP_WRITE = 3'h4
  } psc_op_t;

  typedef enum logic [15:0] {
    PSC_TAP_RESET      = 16'h0001,
    PSC_TAP_IDLE       = 16'h0002,
    PSC_TAP_SEL_DR     = 16'h0004,
    PSC_TAP_CAPTURE_DR = 16'h0008,
    PSC_TAP_SHIFT_DR   = 16'h0010,
    PSC_TAP_EXIT1_DR   = 16'h0020,
    PSC_TAP_PAUSE_DR   = 16'h0040,
    PSC_TAP_EXIT2_DR   = 16'h0080,
    PSC_TAP_UPDATE_DR  = 16'h0100,
    PSC_TAP_SEL_IR     = 16'h0200,
    PSC_TAP_CAPTURE_IR = 16'h0400,
    PSC_TAP_SHIFT_IR   = 16'h0800,
    PSC_TAP_EXIT1_IR   = 16'h1000,
    PSC_TAP_PAUSE_IR   = 16'h2000,
    PSC_TAP_EXIT2_IR   = 16'h4000,
    PSC_TAP_UPDATE_IR  = 16'h8000
  } psc_tap_t;
endpackage : psc_pkg
`default_nettype wire

// >>> hdl/psc_fifo.sv
// synchronous valid/ready fifo with parameterised width and depth
`timescale 1ns/1ps
`default_nettype none
module psc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,       // system clock
  input  wire logic             reset_n,   // async reset, active low
  input  wire logic             in_valid,  // word offered
  output logic                  in_ready,  // room for a word
  input  wire logic [WIDTH-1:0] in_data,   // word in
  output logic                  out_valid, // word available
  input  wire logic             out_ready, // drain takes the word
  output logic      [WIDTH-1:0] out_data   // oldest word
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] store_reg [0:DEPTH-1];
  logic [AW:0]      wr_ptr_reg;
  logic [AW:0]      rd_ptr_reg;
  wire              push;
  wire              pop;
  wire              full;
  wire              empty;

  assign full      = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) && (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
  assign empty     = (wr_ptr_reg == rd_ptr_reg);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign push      = in_valid && !full;
  assign pop       = out_ready && !empty;
  assign out_data  = store_reg[rd_ptr_reg[AW-1:0]];

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pop) rd_ptr_reg <= rd_ptr_reg + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (push) store_reg[wr_ptr_reg[AW-1:0]] <= in_data;
  end
endmodule : psc_fifo
`default_nettype wire

// >>> hdl/psc_sram_pins.sv
// pipelined burst sram: pin control, burst counter, storage and edge-level test port
`timescale 1ns/1ps
`default_nettype none
module psc_sram_pins (
  input  wire logic                         clk,                // memory clock, 25 MHz
  input  wire logic                         reset_n,            // async reset, active low
  input  wire logic                         clock_gate_n,       // clock qualifier, active low
  input  wire logic                         select_low_first,   // chip select, active low
  input  wire logic                         select_high,        // chip select, active high
  input  wire logic                         select_low_second,  // chip select, active low
  input  wire logic                         write_n,            // write strobe, active low
  input  wire logic                         burst_step_or_load, // high advance, low load
  input  wire logic [psc_pkg::ADDR_W-1:0]   addr,               // address inputs
  input  wire logic [psc_pkg::LANES-1:0]    byte_lane_write_n,  // lane write selects, active low
  input  wire logic [psc_pkg::DATA_W-1:0]   dq_in,              // data pins, input side
  output logic      [psc_pkg::DATA_W-1:0]   dq_out,             // data pins, output side
  output logic                              dq_oe,              // data pins driven
  input  wire logic [psc_pkg::LANES-1:0]    parity_lines_in,    // parity pins, input side
  output logic      [psc_pkg::LANES-1:0]    parity_lines_out,   // parity pins, output side
  output logic                              parity_lines_oe,    // parity pins driven
  input  wire logic                         drive_enable_n,     // async output enable, active low
  input  wire logic                         burst_mode_strap,   // high interleaved, low linear
  input  wire logic                         write_drain_hold,   // stalls writes into storage
  output logic                              write_fifo_ready,   // write buffer has room
  output logic                              interleaved_mode,   // captured burst order
  input  wire logic                         tck,                // test clock
  input  wire logic                         tms,                // test mode select
  input  wire logic                         tdi,                // test serial in
  output logic                              tdo,                // test serial out
  output logic                              tdo_oe              // test serial out driven
);
  localparam int AW = psc_pkg::ADDR_W;
  localparam int IW = psc_pkg::MEM_IDX_W;
  localparam int DW = psc_pkg::DATA_W;
  localparam int LN = psc_pkg::LANES;
  localparam int WW = psc_pkg::WORD_W;
  localparam int LW = psc_pkg::LANE_W;

  function automatic psc_pkg::psc_tap_t psc_tap_next(input psc_pkg::psc_tap_t st, input logic m);
    psc_pkg::psc_tap_t nx;
    nx = st;
    unique case (st)
      psc_pkg::PSC_TAP_RESET:      nx = m ? psc_pkg::PSC_TAP_RESET : psc_pkg::PSC_TAP_IDLE;
      psc_pkg::PSC_TAP_IDLE:       nx = m ? psc_pkg::PSC_TAP_SEL_DR : psc_pkg::PSC_TAP_IDLE;
      psc_pkg::PSC_TAP_SEL_DR:     nx = m ? psc_pkg::PSC_TAP_SEL_IR : psc_pkg::PSC_TAP_CAPTURE_DR;
      psc_pkg::PSC_TAP_CAPTURE_DR: nx = m ? psc_pkg::PSC_TAP_EXIT1_DR : psc_pkg::PSC_TAP_SHIFT_DR;
      psc_pkg::PSC_TAP_SHIFT_DR:   nx = m ? psc_pkg::PSC_TAP_EXIT1_DR : psc_pkg::PSC_TAP_SHIFT_DR;
      psc_pkg::PSC_TAP_EXIT1_DR:   nx = m ? psc_pkg::PSC_TAP_UPDATE_DR : psc_pkg::PSC_TAP_PAUSE_DR;
      psc_pkg::PSC_TAP_PAUSE_DR:   nx = m ? psc_pkg::PSC_TAP_EXIT2_DR : psc_pkg::PSC_TAP_PAUSE_DR;
      psc_pkg::PSC_TAP_EXIT2_DR:   nx = m ? psc_pkg::PSC_TAP_UPDATE_DR : psc_pkg::PSC_TAP_SHIFT_DR;
      psc_pkg::PSC_TAP_UPDATE_DR:  nx = m ? psc_pkg::PSC_TAP_SEL_DR : psc_pkg::PSC_TAP_IDLE;
      psc_pkg::PSC_TAP_SEL_IR:     nx = m ? psc_pkg::PSC_TAP_RESET : psc_pkg::PSC_TAP_CAPTURE_IR;
      psc_pkg::PSC_TAP_CAPTURE_IR: nx = m ? psc_pkg::PSC_TAP_EXIT1_IR : psc_pkg::PSC_TAP_SHIFT_IR;
      psc_pkg::PSC_TAP_SHIFT_IR:   nx = m ? psc_pkg::PSC_TAP_EXIT1_IR : psc_pkg::PSC_TAP_SHIFT_IR;
      psc_pkg::PSC_TAP_EXIT1_IR:   nx = m ? psc_pkg::PSC_TAP_UPDATE_IR : psc_pkg::PSC_TAP_PAUSE_IR;
      psc_pkg::PSC_TAP_PAUSE_IR:   nx = m ? psc_pkg::PSC_TAP_EXIT2_IR : psc_pkg::PSC_TAP_PAUSE_IR;
      psc_pkg::PSC_TAP_EXIT2_IR:   nx = m ? psc_pkg::PSC_TAP_UPDATE_IR : psc_pkg::PSC_TAP_SHIFT_IR;
      psc_pkg::PSC_TAP_UPDATE_IR:  nx = m ? psc_pkg::PSC_TAP_SEL_DR : psc_pkg::PSC_TAP_IDLE;
      default:                     nx = psc_pkg::PSC_TAP_RESET;
    endcase
    return nx;
  endfunction : psc_tap_next

  // ---------------- asynchronous pins: two-flop synchronisers ----------------
  logic [4:0] async_s1_reg;
  logic [4:0] async_s2_reg;
  logic       tck_s3_reg;
  wire        oe_n_sync;
  wire        strap_sync;
  wire        tck_sync;
  wire        tms_sync;
  wire        tdi_sync;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      async_s1_reg <= 5'h01;
      async_s2_reg <= 5'h01;
      tck_s3_reg   <= 1'b0;
    end else begin
      async_s1_reg <= {tdi, tms, tck, burst_mode_strap, drive_enable_n};
      async_s2_reg <= async_s1_reg;
      tck_s3_reg   <= async_s2_reg[2];
    end
  end

  assign oe_n_sync  = async_s2_reg[0];
  assign strap_sync = async_s2_reg[1];
  assign tck_sync   = async_s2_reg[2];
  assign tms_sync   = async_s2_reg[3];
  assign tdi_sync   = async_s2_reg[4];

  // ---------------- burst-order strap, caught once after reset ----------------
  logic [1:0] strap_wait_reg;
  logic       mode_reg;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      strap_wait_reg <= 2'h0;
      mode_reg       <= psc_pkg::MODE_RESET;
    end else if (strap_wait_reg != psc_pkg::STRAP_WAIT) begin
      strap_wait_reg <= strap_wait_reg + 2'h1;
      // taken once: a strap that moves later is not followed
      if (strap_wait_reg == psc_pkg::STRAP_WAIT - 2'h1) mode_reg <= strap_sync;
    end
  end

  assign interleaved_mode = mode_reg;

  // ---------------- address stage ----------------
  wire                qualified;
  wire                selected;
  wire                load;
  psc_pkg::psc_op_t   op_reg;
  psc_pkg::psc_op_t   op_next;
  logic [AW-1:0]      base_reg;
  logic [1:0]         start_lo_reg;
  logic [1:0]         beat_reg;
  logic [LN-1:0]      lanes_reg;
  wire  [1:0]         burst_lo;
  wire  [IW-1:0]      cur_idx;

  assign qualified = !clock_gate_n;
  assign selected  = !select_low_first && select_high && !select_low_second;
  assign load      = !burst_step_or_load;
  assign burst_lo  = mode_reg ? (start_lo_reg ^ beat_reg) : (start_lo_reg + beat_reg);
  assign cur_idx   = {base_reg[IW-1:2], burst_lo};
  // an advance continues the latched operation whatever the selects say
  assign op_next   = !load ? op_reg :
                     !selected ? psc_pkg::PSC_OP_IDLE :
                     write_n ? psc_pkg::PSC_OP_READ : psc_pkg::PSC_OP_WRITE;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      op_reg       <= psc_pkg::PSC_OP_IDLE;
      base_reg     <= '0;
      start_lo_reg <= 2'h0;
      beat_reg     <= 2'h0;
      lanes_reg    <= '1;
    end else if (qualified) begin
      op_reg    <= op_next;
      lanes_reg <= byte_lane_write_n;
      if (load && selected) begin
        base_reg     <= addr;
        start_lo_reg <= addr[1:0];
      end
      beat_reg <= load ? 2'h0 : beat_reg + 2'h1;
    end
  end

  // ---------------- storage ----------------
  wire  [DW-1:0] rd_data;
  wire  [LN-1:0] rd_par;
  wire           drain;
  wire           fifo_in_ready;
  wire           fifo_out_valid;
  wire           fifo_out_ready;
  wire  [WW-1:0] fifo_out_word;
  wire  [WW-1:0] fifo_in_word;
  wire           fifo_in_valid;
  wire  [IW-1:0] wr_idx;
  wire  [DW-1:0] wr_data;
  wire  [LN-1:0] wr_par;
  wire  [LN-1:0] wr_lanes_n;

  // write data phase: pins are registered into the buffer on the qualified edge
  assign fifo_in_valid  = qualified && (op_reg == psc_pkg::PSC_OP_WRITE);
  assign fifo_in_word   = {cur_idx, dq_in, parity_lines_in, lanes_reg};
  // suspend freezes storage too, so the drain also waits on the gate
  assign fifo_out_ready = qualified && !write_drain_hold;
  assign {wr_idx, wr_data, wr_par, wr_lanes_n} = fifo_out_word;

  psc_fifo #(
    .WIDTH (WW),
    .DEPTH (psc_pkg::FIFO_DEPTH)
  ) u_write_fifo (
    .clk       (clk),
    .reset_n   (reset_n),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in_word),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_word)
  );

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) write_fifo_ready <= 1'b1;
    else write_fifo_ready <= fifo_in_ready;
  end

  assign drain = fifo_out_valid && fifo_out_ready;

  genvar g;
  generate
    for (g = 0; g < LN; g++) begin : g_lane
      // byte plus its parity bit per entry, so each lane's storage has a single writer
      logic [LW:0] lane_mem [0:(1<<IW)-1];
      wire         lane_hit;
      wire  [LW:0] lane_wr;

      assign lane_wr  = {wr_par[g], wr_data[g*LW +: LW]};
      // a word landing on the read's data edge is passed through, so write then read sees new data
      assign lane_hit = drain && !wr_lanes_n[g] && (wr_idx == cur_idx);
      assign {rd_par[g], rd_data[g*LW +: LW]} = lane_hit ? lane_wr : lane_mem[cur_idx];

      always_ff @(posedge clk) begin
        if (drain && !wr_lanes_n[g]) lane_mem[wr_idx] <= lane_wr;
      end
    end
  endgenerate

  // ---------------- read data phase and output drive ----------------
  logic rd_valid_reg;
  wire  rd_valid_next;
  wire  drive_next;

  // only a read in its data phase may drive; writes, deselect and its first clock stay off
  assign rd_valid_next = qualified ? (op_reg == psc_pkg::PSC_OP_READ) : rd_valid_reg;
  assign drive_next    = rd_valid_next && !oe_n_sync;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_valid_reg     <= 1'b0;
      dq_out           <= '0;
      parity_lines_out <= '0;
      dq_oe            <= 1'b0;
      parity_lines_oe  <= 1'b0;
    end else begin
      rd_valid_reg    <= rd_valid_next;
      dq_oe           <= drive_next;
      parity_lines_oe <= drive_next;
      if (qualified && op_reg == psc_pkg::PSC_OP_READ) begin
        dq_out           <= rd_data;
        parity_lines_out <= rd_par;
      end
    end
  end

  // ---------------- test access port, edge level only ----------------
  psc_pkg::psc_tap_t tap_reg;
  logic              shift_bit_reg;
  wire               tck_rise;
  wire               tck_fall;
  wire               shifting;

  assign tck_rise = tck_sync && !tck_s3_reg;
  assign tck_fall = !tck_sync && tck_s3_reg;
  assign shifting = (tap_reg == psc_pkg::PSC_TAP_SHIFT_DR) || (tap_reg == psc_pkg::PSC_TAP_SHIFT_IR);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tap_reg       <= psc_pkg::PSC_TAP_RESET;
      shift_bit_reg <= 1'b0;
    end else if (tck_rise) begin
      tap_reg <= psc_tap_next(tap_reg, tms_sync);
      if (shifting) shift_bit_reg <= tdi_sync;
      else if (tap_reg == psc_pkg::PSC_TAP_CAPTURE_IR) shift_bit_reg <= psc_pkg::IR_CAPTURE;
      else if (tap_reg == psc_pkg::PSC_TAP_CAPTURE_DR) shift_bit_reg <= psc_pkg::DR_CAPTURE;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tdo    <= 1'b0;
      tdo_oe <= 1'b0;
    end else if (tck_fall) begin
      tdo    <= shift_bit_reg;
      tdo_oe <= shifting;
    end
  end
endmodule : psc_sram_pins
`default_nettype wire

// >>> dv/psc_sram_pins_checker.sv
// concurrent checks on the pin-control ports of the sram block
`timescale 1ns/1ps
`default_nettype none
module psc_sram_pins_checker (
  input wire logic                        clk,                // clock
  input wire logic                        reset_n,            // reset
  input wire logic                        clock_gate_n,       // gate
  input wire logic                        select_low_first,   // select
  input wire logic                        select_high,        // select
  input wire logic                        select_low_second,  // select
  input wire logic                        write_n,            // strobe
  input wire logic                        burst_step_or_load, // step
  input wire logic [psc_pkg::DATA_W-1:0]  dq_out,             // data
  input wire logic                        dq_oe,              // data drive
  input wire logic [psc_pkg::LANES-1:0]   parity_lines_out,   // parity
  input wire logic                        parity_lines_oe,    // parity drive
  input wire logic                        drive_enable_n,     // enable
  input wire logic                        burst_mode_strap,   // strap
  input wire logic                        interleaved_mode,   // order
  input wire logic                        tck,                // test clock
  input wire logic                        tdo,                // test out
  input wire logic                        tdo_oe              // test drive
);
  logic [2:0] up_cnt;
  wire        sel_ok = !select_low_first && select_high && !select_low_second;
  wire        load_q = !clock_gate_n && !burst_step_or_load;
  wire        oe_on  = !drive_enable_n;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      up_cnt <= 3'h0;
    end else if (up_cnt != 3'h7) begin
      up_cnt <= up_cnt + 3'h1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_oe_pair_match: assert property (dq_oe == parity_lines_oe) else $error("drive of data and parity differ");
  a_write_no_drive: assert property (load_q && sel_ok && !write_n ##1 !clock_gate_n |=> !dq_oe)
    else $error("pins driven in write data phase");
  a_deselect_quiet: assert property (load_q && !sel_ok ##1 !clock_gate_n |=> !dq_oe)
    else $error("pins driven after deselect");
  a_read_drives: assert property (oe_on && $past(oe_on) && $past(oe_on, 2) && load_q && sel_ok && write_n
    ##1 !clock_gate_n |=> dq_oe) else $error("read data not driven");
  a_oe_masked: assert property (!oe_on && !$past(oe_on) && !$past(oe_on, 2) && !$past(oe_on, 3) |-> !dq_oe)
    else $error("pins driven while enable high");
  a_gate_freeze: assert property (clock_gate_n |=> $stable(dq_out) && $stable(parity_lines_out))
    else $error("output changed on masked edge");
  a_mode_settles: assert property ($changed(interleaved_mode) |-> up_cnt <= 3'h4)
    else $error("burst order changed late");
  a_mode_strap: assert property (up_cnt == 3'h7 |-> interleaved_mode == burst_mode_strap)
    else $error("burst order differs from strap");
  a_tdo_on_fall: assert property ($changed(tdo) || $changed(tdo_oe) |-> !$past(tck, 2))
    else $error("test output moved outside falling test clock");
endmodule : psc_sram_pins_checker
`default_nettype wire

// >>> dv/psc_host_model.sv
// host memory controller model driving the synchronous sram port
`timescale 1ns/1ps
`default_nettype none
module psc_host_model (
  input  wire logic                       clk,                // clock
  output logic                            clock_gate_n,       // gate
  output logic                            select_low_first,   // select
  output logic                            select_high,        // select
  output logic                            select_low_second,  // select
  output logic                            write_n,            // strobe
  output logic                            burst_step_or_load, // step
  output logic [psc_pkg::ADDR_W-1:0]      addr,               // address
  output logic [psc_pkg::LANES-1:0]       byte_lane_write_n,  // lanes
  output logic [psc_pkg::DATA_W-1:0]      dq_in,              // data
  output logic [psc_pkg::LANES-1:0]       parity_lines_in     // parity
);
  logic        wr_pend;
  logic [35:0] wr_word;
  initial begin
    {clock_gate_n, select_low_first, select_high, select_low_second, write_n, burst_step_or_load} = 6'h02;
    {addr, byte_lane_write_n, dq_in, parity_lines_in, wr_pend, wr_word} = '0;
  end
  // kind 1 read, 2 write, 3 advance; sel packs first, high and second selects
  task automatic op(input logic [1:0] kind, input logic [2:0] sel, input logic [psc_pkg::ADDR_W-1:0] a,
                    input logic [psc_pkg::LANES-1:0] ln, input logic [35:0] wd);
    @(negedge clk);
    // a released bus shows the inverse of its last value so a stale copy cannot match
    {dq_in, parity_lines_in} = wr_pend ? wr_word : ~{dq_in, parity_lines_in};
    {select_low_first, select_high, select_low_second} = sel;
    write_n            = (kind != 2'h2);
    burst_step_or_load = (kind == 2'h3);
    addr               = a;
    byte_lane_write_n  = ln;
    wr_pend            = (kind == 2'h2);
    wr_word            = wd;
  endtask : op
  task automatic gate(input int n);
    @(negedge clk);
    clock_gate_n = 1'h1;
    repeat (n) @(negedge clk);
    clock_gate_n = 1'h0;
  endtask : gate
endmodule : psc_host_model
`default_nettype wire

// >>> dv/psc_sram_pins_tb.sv
// self-checking bench for the sram pin-control block
`timescale 1ns/1ps
`default_nettype none
module psc_sram_pins_tb;
  logic clk = 1'h0, reset_n = 1'h0, drive_enable_n = 1'h0, write_drain_hold = 1'h0;
  logic tck = 1'h0, tms = 1'h1, tdi = 1'h0, oe_off = 1'h0, rd = 1'h0;
  logic burst_mode_strap = 1'h1;
  logic clock_gate_n, select_low_first, select_high, select_low_second, write_n, burst_step_or_load;
  logic dq_oe, parity_lines_oe, write_fifo_ready, interleaved_mode, tdo, tdo_oe;
  logic [17:0] addr, base, ga, gb;
  logic [3:0]  byte_lane_write_n, parity_lines_in, parity_lines_out;
  logic [31:0] dq_in, dq_out;
  logic [1:0]  beat = 2'h0;
  logic [35:0] mem [64];
  logic [36:0] expq [$];
  int          fails = 0, checked = 0;
  always #20 clk = ~clk;
  psc_host_model host (.clk, .clock_gate_n, .select_low_first, .select_high, .select_low_second, .write_n,
    .burst_step_or_load, .addr, .byte_lane_write_n, .dq_in, .parity_lines_in);
  psc_sram_pins uut (.clk, .reset_n, .clock_gate_n, .select_low_first, .select_high, .select_low_second, .write_n,
    .burst_step_or_load, .addr, .byte_lane_write_n, .dq_in, .dq_out, .dq_oe, .parity_lines_in, .parity_lines_out,
    .parity_lines_oe, .drive_enable_n, .burst_mode_strap, .write_drain_hold, .write_fifo_ready, .interleaved_mode,
    .tck, .tms, .tdi, .tdo, .tdo_oe);
  task automatic compare(input string nm, input logic [35:0] e, input logic [35:0] g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : compare
  task automatic end_of_test;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_of_test
  // one operation per qualified edge; its result is seen two operations later
  task automatic step(input logic [1:0] kind, input logic [2:0] sel, input logic [17:0] a, input logic [3:0] ln);
    logic [35:0] wd;
    logic [17:0] ea;
    logic [36:0] e;
    wd = {$urandom(), 4'($urandom())};
    if (kind == 2'h3) begin
      beat = beat + 2'h1;
    end else begin
      base = a;
      beat = 2'h0;
      rd   = (kind == 2'h1) && (sel == 3'h2);
    end
    ea = {base[17:2], burst_mode_strap ? base[1:0] ^ beat : base[1:0] + beat};
    host.op(kind, sel, a, ln, wd);
    if (kind == 2'h2 && sel == 3'h2) for (int i = 0; i < 4; i++) if (!ln[i]) begin
      mem[ea[5:0]][4+8*i +: 8] = wd[4+8*i +: 8];
      mem[ea[5:0]][i]          = wd[i];
    end
    if (expq.size() == 2) begin
      e = expq.pop_front();
      compare("dq_oe", {35'h0, e[36] && !oe_off}, {35'h0, dq_oe});
      if (e[36] && !oe_off) compare("read word", e[35:0], {dq_out, parity_lines_out});
    end
    expq.push_back({rd, mem[ea[5:0]]});
  endtask : step
  task automatic flush;
    repeat (2) step(2'h1, 3'h0, 18'h0, 4'hF);
  endtask : flush
  task automatic bursts;
    for (int i = 0; i < 8; i++) begin
      step(2'h1, 3'h2, 18'($urandom), 4'hF);
      repeat (5) step(2'h3, 3'($urandom), 18'($urandom), 4'($urandom));
    end
    flush();
  endtask : bursts
  // one test clock period, tms and tdi set a half period before the rise
  task automatic tap_clk(input logic m, input logic d);
    tms = m;
    tdi = d;
    repeat (5) @(negedge clk);
    tck = 1'h1;
    repeat (5) @(negedge clk);
    tck = 1'h0;
  endtask : tap_clk
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    end_of_test();
  end
  initial begin
    void'($urandom(32'h1AC9FCA1));
    repeat (4) @(negedge clk);
    reset_n = 1'h1;
    repeat (4) @(negedge clk);
    compare("interleaved_mode", 36'h1, {35'h0, interleaved_mode});
    for (int i = 0; i < 64; i++) step(2'h2, 3'h2, 18'(i), 4'h0);
    for (int i = 0; i < 300; i++) step(2'(1 + $urandom_range(1)), 3'h2, 18'($urandom), 4'($urandom));
    for (int s = 0; s < 8; s++) step(2'h1, 3'(s), 18'($urandom), 4'hF);
    bursts();
    ga = 18'($urandom);
    gb = 18'($urandom);
    step(2'h1, 3'h2, ga, 4'hF);
    step(2'h1, 3'h2, gb, 4'hF);
    host.gate(3);
    compare("frozen word", mem[ga[5:0]], {dq_out, parity_lines_out});
    @(negedge clk);
    compare("stretched read", mem[gb[5:0]], {dq_out, parity_lines_out});
    expq.delete();
    flush();
    drive_enable_n = 1'h1;
    oe_off = 1'h1;
    flush();
    for (int i = 0; i < 6; i++) step(2'h1, 3'h2, 18'($urandom), 4'hF);
    flush();
    drive_enable_n = 1'h0;
    oe_off = 1'h0;
    flush();
    write_drain_hold = 1'h1;
    for (int i = 0; i < 16; i++) step(2'h2, 3'h2, 18'($urandom), 4'($urandom));
    flush();
    // the ready flag is registered, one edge behind the buffer filling
    @(negedge clk);
    compare("write_fifo_ready", 36'h0, {35'h0, write_fifo_ready});
    write_drain_hold = 1'h0;
    for (int w = 0; w < 40 && write_fifo_ready !== 1'h1; w++) step(2'h1, 3'h0, 18'h0, 4'hF);
    compare("write_fifo_ready", 36'h1, {35'h0, write_fifo_ready});
    // let the queued writes drain; a read of a still-queued word returns old data
    repeat (8) flush();
    for (int i = 0; i < 64; i++) step(2'h1, 3'h2, 18'(i), 4'hF);
    flush();
    // second reset with the strap low: linear order from a mid-run restart
    reset_n = 1'h0;
    burst_mode_strap = 1'h0;
    expq.delete();
    repeat (4) @(negedge clk);
    reset_n = 1'h1;
    repeat (4) @(negedge clk);
    compare("interleaved_mode", 36'h0, {35'h0, interleaved_mode});
    bursts();
    for (int i = 0; i < 40; i++) begin
      repeat (5) @(negedge clk);
      tck = ~tck;
      if (!tck) begin
        tms = (i > 28) | 1'($urandom);
        tdi = 1'($urandom);
      end
    end
    tap_clk(1'h0, 1'h0);
    tap_clk(1'h1, 1'h0);
    tap_clk(1'h0, 1'h0);
    tap_clk(1'h0, 1'h0);
    tap_clk(1'h0, 1'h1);
    repeat (8) @(negedge clk);
    compare("tdo", 36'h1, {35'h0, tdo});
    compare("tdo_oe", 36'h1, {35'h0, tdo_oe});
    repeat (5) tap_clk(1'h1, 1'h0);
    repeat (8) @(negedge clk);
    compare("tdo_oe", 36'h0, {35'h0, tdo_oe});
    end_of_test();
  end
endmodule : psc_sram_pins_tb
bind psc_sram_pins psc_sram_pins_checker chk_i (.clk, .reset_n, .clock_gate_n, .select_low_first, .select_high,
  .select_low_second, .write_n, .burst_step_or_load, .dq_out, .dq_oe, .parity_lines_out, .parity_lines_oe,
  .drive_enable_n, .burst_mode_strap, .interleaved_mode, .tck, .tdo, .tdo_oe);
`default_nettype wire
